//--- rtl/strobe_port_map.svh
// Constants for the centered read strobe port: widths, command fields and timing counts.
`ifndef STROBE_PORT_MAP_SVH
`define STROBE_PORT_MAP_SVH
`define DQ_W            8
`define CA_BYTES        6
`define CA_RD_BIT       47
`define LAT_CLKS        4
`define LAT_EXTRA_DEF   1'b0
`define CNT_W           8
`define SYNC_RST_LVL    6'h30
`endif

//--- rtl/strobe_port_pkg.sv
// Types shared by the centered read strobe port.
package strobe_port_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CA   = 3'b001,
    ST_LAT  = 3'b010,
    ST_RD   = 3'b011,
    ST_WR   = 3'b100
  } phase_e;
  typedef logic [7:0] byte_t;
endpackage

//--- rtl/pin_sync.sv
// Two-flop synchroniser with edge detection behind the second flop.
`timescale 1ns/1ps
module pin_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_LVL = '1  // Idle level of each pin, loaded in reset.
) (
  input  wire logic         i_clk,   // System clock.
  input  wire logic         i_rst,   // Synchronous reset.
  input  wire logic [W-1:0] i_pin,   // Asynchronous pins.
  output logic      [W-1:0] o_lvl,   // Synchronised level.
  output logic      [W-1:0] o_rise,  // One-cycle rising pulse.
  output logic      [W-1:0] o_fall   // One-cycle falling pulse.
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // Each bit passes two flops; the third only serves the edge detector.
  // Reset loads the pin's idle level, so no false edge appears after reset.
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          s1_q[g] <= RST_LVL[g];
          s2_q[g] <= RST_LVL[g];
          s3_q[g] <= RST_LVL[g];
        end else begin
          s1_q[g] <= i_pin[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
        end
      end
      assign o_rise[g] = s2_q[g] & ~s3_q[g];
      assign o_fall[g] = ~s2_q[g] & s3_q[g];
    end
  endgenerate
  assign o_lvl = s2_q;
endmodule

//--- rtl/strobe_port.sv
// Device end of the parallel memory port with a phase-shifted read strobe clock.
`timescale 1ns/1ps
`include "strobe_port_map.svh"
// Function
// R1 - Select falling edge starts a transaction
// R2 - Select rising edge ends the transaction
// R3 - Differential clock uses true/complement crossing
// R4 - Single-ended mode ignores complement clock
// R5 - Stopped bus clock between transfers tolerated
// R6 - Shifted clock pair used when differential
// R7 - Host holds shifted clock static on writes
// R8 - Read strobe edges follow shifted clock
// R9 - Device drives strobe during read data
// R10 - Write strobe is host byte mask
// R11 - Strobe flags extra latency at start
// R12 - Eight data lanes carry command and data
// R13 - Reset low returns device to idle
// R14 - Reset low floats strobe and data
// R15 - Host starts with clock low
// R16 - Host ends transaction before next one
// R17 - Host sets shifted clock phase
// R18 - Shifted clock ignored during writes
// R19 - Host normally uses ninety degree shift
// R20 - Bus released when select returns high
module strobe_port
  import strobe_port_pkg::*;
(
  input  wire logic                I_CLK,        // 125 MHz system clock.
  input  wire logic                I_SYS_RST,    // Synchronous reset, active high.
  input  wire logic                I_RESET_N,    // Hardware reset pin, active low.
  input  wire logic                I_DIFF_MODE,  // High selects the differential clocks.
  input  wire logic                I_LAT_EXTRA,  // High when extra latency is needed.
  input  wire logic                I_CS_N,       // Chip select pin, active low.
  input  wire logic                I_BUS_CLK_P,  // Bus clock, true.
  input  wire logic                I_BUS_CLK_N,  // Bus clock, complement.
  input  wire logic                I_SHIFTED_CLK_P, // Phase-shifted clock, true.
  input  wire logic                I_SHIFTED_CLK_N, // Phase-shifted clock, complement.
  input  wire logic [`DQ_W-1:0]    I_DQ,         // Data lanes in.
  output logic      [`DQ_W-1:0]    O_DQ,         // Data lanes out.
  output logic                     O_DQ_OE_N,    // Data lane enable, low drives.
  input  wire logic                I_DATA_STROBE_MASK, // Strobe pin in.
  output logic                     O_DATA_STROBE_MASK, // Strobe pin out.
  output logic                     O_DATA_STROBE_MASK_OE_N, // Strobe enable, low drives.
  input  wire strobe_port_pkg::byte_t I_RD_DATA, // Read data from the core.
  output logic                     O_RD_ACK,     // Pulse: read byte consumed.
  output logic [47:0]              O_CMD_ADDR,   // Captured command-address word.
  output logic                     O_CMD_VALID,  // Pulse: command-address complete.
  output strobe_port_pkg::byte_t   O_WR_DATA,    // Written byte.
  output logic                     O_WR_VALID,   // Pulse: written byte unmasked.
  output logic                     O_BUSY        // Transaction in progress.
);
  import strobe_port_pkg::*;

  logic [5:0] lvl;
  logic [5:0] rise;
  logic [5:0] fall;
  logic       cs_start;
  logic       cs_end;
  logic       bus_edge;
  logic       psc_edge;
  logic       in_reset;
  phase_e     st_q;
  logic [`CNT_W-1:0] cnt_q;
  logic [47:0] ca_q;
  logic       extra_q;
  logic       data_strobe_mask_q;
  logic       data_strobe_mask_oe_n_q;
  logic [`DQ_W-1:0] dq_q;
  logic       dq_oe_n_q;
  logic       cmd_valid_q;
  logic       rd_ack_q;
  byte_t      wr_q;
  logic       wr_valid_q;
  logic [`DQ_W-1:0] dq_s1_q;
  logic [`DQ_W-1:0] dq_s2_q;
  logic       data_strobe_mask_s1_q;
  logic       data_strobe_mask_s2_q;

  // The six control pins pass two flops before any logic reads them.
  pin_sync #(.W(6), .RST_LVL(`SYNC_RST_LVL)) u_sync (
    .i_clk  (I_CLK),
    .i_rst  (I_SYS_RST),
    .i_pin  ({I_RESET_N, I_CS_N, I_BUS_CLK_P, I_BUS_CLK_N,
              I_SHIFTED_CLK_P, I_SHIFTED_CLK_N}),
    .o_lvl  (lvl),
    .o_rise (rise),
    .o_fall (fall)
  );

  // Data and strobe pins are synchronised alongside the control pins.
  always_ff @(posedge I_CLK) begin
    dq_s1_q   <= I_DQ;
    dq_s2_q   <= dq_s1_q;
    data_strobe_mask_s1_q <= I_DATA_STROBE_MASK;
    data_strobe_mask_s2_q <= data_strobe_mask_s1_q;
  end

  // Transaction framing and clock edge selection.
  assign in_reset = I_SYS_RST | ~lvl[5]; // R13
  assign cs_start = fall[4]; // R1
  assign cs_end   = rise[4]; // R2
  // In differential mode an edge counts only where true and complement cross.
  assign bus_edge = I_DIFF_MODE ? ((rise[3] & fall[2]) | (fall[3] & rise[2]))
                                : (rise[3] | fall[3]); // R3 R4 R5
  assign psc_edge = I_DIFF_MODE ? ((rise[1] & fall[0]) | (fall[1] & rise[0]))
                                : (rise[1] | fall[1]); // R6 R8

  // Phase sequencer: command bytes, latency, then read or write data.
  always_ff @(posedge I_CLK) begin
    if (in_reset) begin
      st_q    <= ST_IDLE; // R13
      cnt_q   <= '0;
      ca_q    <= '0;
      extra_q <= `LAT_EXTRA_DEF;
    end else if (cs_end) begin
      st_q <= ST_IDLE; // R2
    end else if (cs_start) begin
      st_q    <= ST_CA; // R1
      cnt_q   <= '0;
      extra_q <= I_LAT_EXTRA;
    end else if (bus_edge) begin
      case (st_q)
        ST_CA: begin
          ca_q  <= {ca_q[39:0], dq_s2_q}; // R12
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == `CNT_W'(`CA_BYTES - 1)) begin
            cnt_q <= '0;
            st_q  <= ST_LAT;
          end
        end
        ST_LAT: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == (extra_q ? `CNT_W'(4 * `LAT_CLKS - 1)
                                : `CNT_W'(2 * `LAT_CLKS - 1))) begin // R11
            cnt_q <= '0;
            st_q  <= ca_q[`CA_RD_BIT] ? ST_RD : ST_WR;
          end
        end
        default: st_q <= st_q;
      endcase
    end
  end

  // Command capture pulse when the last address byte is taken.
  always_ff @(posedge I_CLK) begin
    if (in_reset) begin
      cmd_valid_q <= 1'b0;
    end else begin
      cmd_valid_q <= bus_edge & ~cs_end & (st_q == ST_CA)
                     & (cnt_q == `CNT_W'(`CA_BYTES - 1));
    end
  end

  // Strobe pin: latency flag at start, shifted-clock toggles in reads.
  always_ff @(posedge I_CLK) begin
    if (in_reset || cs_end || st_q == ST_IDLE) begin
      data_strobe_mask_q      <= 1'b0;
      data_strobe_mask_oe_n_q <= 1'b1; // R14 R20
    end else if (st_q == ST_CA) begin
      data_strobe_mask_q      <= extra_q; // R11
      data_strobe_mask_oe_n_q <= 1'b0;
    end else if (st_q == ST_RD) begin
      data_strobe_mask_oe_n_q <= 1'b0; // R9
      if (psc_edge) begin
        data_strobe_mask_q <= ~data_strobe_mask_q; // R8
      end
    end else begin
      data_strobe_mask_q      <= 1'b0;
      data_strobe_mask_oe_n_q <= 1'b1; // R10 R18
    end
  end

  // Data lanes: driven with core data on bus edges during reads.
  always_ff @(posedge I_CLK) begin
    if (in_reset || cs_end || st_q != ST_RD) begin
      dq_q      <= '0;
      dq_oe_n_q <= 1'b1; // R14 R20
      rd_ack_q  <= 1'b0;
    end else begin
      dq_oe_n_q <= 1'b0; // R12
      rd_ack_q  <= bus_edge;
      if (bus_edge) begin
        dq_q <= I_RD_DATA;
      end
    end
  end

  // Write bytes: the strobe masks each byte; shifted clocks are not read here.
  always_ff @(posedge I_CLK) begin
    if (in_reset) begin
      wr_q       <= '0;
      wr_valid_q <= 1'b0;
    end else begin
      wr_valid_q <= bus_edge & ~cs_end & (st_q == ST_WR) & ~data_strobe_mask_s2_q; // R10 R18
      if (bus_edge && st_q == ST_WR) begin
        wr_q <= dq_s2_q;
      end
    end
  end

  assign O_DQ                    = dq_q;
  assign O_DQ_OE_N               = dq_oe_n_q;
  assign O_DATA_STROBE_MASK      = data_strobe_mask_q;
  assign O_DATA_STROBE_MASK_OE_N = data_strobe_mask_oe_n_q;
  assign O_RD_ACK                = rd_ack_q;
  assign O_CMD_ADDR              = ca_q;
  assign O_CMD_VALID             = cmd_valid_q;
  assign O_WR_DATA               = wr_q;
  assign O_WR_VALID              = wr_valid_q;
  assign O_BUSY                  = (st_q != ST_IDLE);

  // Checks.
  sequence s_cs_rise;
    cs_end;
  endsequence
  sequence s_released;
    data_strobe_mask_oe_n_q && dq_oe_n_q;
  endsequence
  AST_RESET_IDLE: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    !lvl[5] |=> st_q == ST_IDLE) else $error("Reset pin did not idle."); // R13
  AST_RESET_FLOAT: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    !lvl[5] |=> s_released) else $error("Pins driven in reset."); // R14
  AST_CS_END: assert property (@(posedge I_CLK) disable iff (in_reset)
    s_cs_rise |=> st_q == ST_IDLE ##0 s_released) else $error("No release at end."); // R2
  AST_CS_START: assert property (@(posedge I_CLK) disable iff (in_reset)
    cs_start && !cs_end |=> st_q == ST_CA) else $error("Start not seen."); // R1
  AST_LAT_FLAG: assert property (@(posedge I_CLK) disable iff (in_reset)
    st_q == ST_CA && $past(st_q) == ST_CA && !cs_end |=> !data_strobe_mask_oe_n_q
    && data_strobe_mask_q == extra_q) else $error("Latency flag wrong."); // R11
  AST_RD_DRIVE: assert property (@(posedge I_CLK) disable iff (in_reset)
    st_q == ST_RD && !cs_end |=> !data_strobe_mask_oe_n_q) else $error("Read strobe undriven."); // R9
  AST_STROBE_PSC: assert property (@(posedge I_CLK) disable iff (in_reset)
    st_q == ST_RD && $past(st_q) == ST_RD && !cs_end && !psc_edge
    |=> $stable(data_strobe_mask_q)) else $error("Strobe moved without shifted clock."); // R8
  AST_WR_FLOAT: assert property (@(posedge I_CLK) disable iff (in_reset)
    st_q == ST_WR |=> data_strobe_mask_oe_n_q && dq_oe_n_q) else $error("Driven during write."); // R10
  AST_WR_MASK: assert property (@(posedge I_CLK) disable iff (in_reset)
    st_q == ST_WR && bus_edge && data_strobe_mask_s2_q |=> !O_WR_VALID)
    else $error("Masked byte passed."); // R10
endmodule

//--- bench/host_model.sv
// Host model that frames transfers on the bus clock and the phase-shifted clock.
`timescale 1ns/1ps
module host_model (
  output logic       o_cs_n,  // Select, active low.
  output logic       o_ck_p,  // Bus clock, true.
  output logic       o_ck_n,  // Bus clock, complement.
  output logic       o_sk_p,  // Shifted clock, true.
  output logic       o_sk_n,  // Shifted clock, complement.
  output logic [7:0] o_dq,    // Data lanes while the host drives them.
  output logic       o_mask   // Write byte mask while the host drives it.
);
  logic diff_q;
  // Idle bus: select high, clocks stopped low.
  initial begin
    o_cs_n = 1'b1;
    o_ck_p = 1'b0;
    o_ck_n = 1'b0;
    o_sk_p = 1'b0;
    o_sk_n = 1'b0;
    o_dq = 8'h5A;
    o_mask = 1'b0;
    diff_q = 1'b0;
  end
  // One bus clock half period; the shifted clock lags by a quarter period.
  task automatic half(input logic [7:0] b, input logic m, input logic shift);
    o_dq = b;
    o_mask = m;
    #16;
    o_ck_p = ~o_ck_p;
    o_ck_n = diff_q ? ~o_ck_p : 1'b0;
    #16;
    if (shift) begin
      o_sk_p = ~o_sk_p;
      o_sk_n = diff_q ? ~o_sk_p : 1'b0;
    end
  endtask
  // A whole transfer; released lines carry an inverted pattern, not the last value.
  task automatic frame(input logic diff, input logic lat, input logic [47:0] ca,
                       input int nd, input logic [7:0] mk);
    diff_q = diff;
    o_ck_n = diff;
    o_sk_n = diff & ca[47];
    o_cs_n = 1'b0;
    #32;
    for (int i = 5; i >= 0; i--) half(ca[8*i +: 8], ~o_mask, 1'b0);
    for (int i = 0; i < (lat ? 16 : 8); i++) half(~o_dq, ~o_mask, 1'b0);
    for (int i = 0; i < nd; i++) half(ca[47] ? ~o_dq : 8'hC0 + 8'(i),
                                      ca[47] ? ~o_mask : mk[i], ca[47]);
    #32;
    o_cs_n = 1'b1;
    #64;
  endtask
endmodule

//--- bench/centered_read_strobe_port_tb_top.sv
// Self-checking bench for the centered read strobe port.
`timescale 1ns/1ps
module centered_read_strobe_port_tb_top;
  import strobe_port_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, rst_n = 1'b1, diff = 1'b0, lat = 1'b0;
  logic        cs_n, ckp, ckn, skp, skn, hmask, m_o, m_oe_n, dq_oe_n, m_prev;
  logic        rd_ack, cmd_valid, wr_valid, busy;
  logic [7:0]  hdq, dq_o, last_rd, last_wr, rd_data = 8'h10;
  logic [47:0] cmd_addr;
  byte_t       wr_data;
  int          errors = 0, check_count = 0, acks = 0, wrs = 0, togs = 0, cmds = 0;
  // Free-running 125 MHz clock.
  always #4 clk = ~clk;
  host_model host (.o_cs_n(cs_n), .o_ck_p(ckp), .o_ck_n(ckn), .o_sk_p(skp),
                   .o_sk_n(skn), .o_dq(hdq), .o_mask(hmask));
  strobe_port dut (.I_CLK(clk), .I_SYS_RST(rst), .I_RESET_N(rst_n), .I_DIFF_MODE(diff),
    .I_LAT_EXTRA(lat), .I_CS_N(cs_n), .I_BUS_CLK_P(ckp), .I_BUS_CLK_N(ckn),
    .I_SHIFTED_CLK_P(skp), .I_SHIFTED_CLK_N(skn), .I_DQ(dq_oe_n ? hdq : dq_o),
    .O_DQ(dq_o), .O_DQ_OE_N(dq_oe_n), .I_DATA_STROBE_MASK(m_oe_n ? hmask : m_o),
    .O_DATA_STROBE_MASK(m_o), .O_DATA_STROBE_MASK_OE_N(m_oe_n), .I_RD_DATA(rd_data),
    .O_RD_ACK(rd_ack), .O_CMD_ADDR(cmd_addr), .O_CMD_VALID(cmd_valid),
    .O_WR_DATA(wr_data), .O_WR_VALID(wr_valid), .O_BUSY(busy));
  // Counts pulses and driven strobe toggles, and feeds the next read byte.
  always @(negedge clk) begin
    cmds += int'(cmd_valid === 1'b1);
    if (rd_ack === 1'b1) begin
      acks++;
      last_rd = dq_o;
      rd_data = rd_data + 8'h01;
    end
    if (wr_valid === 1'b1) begin
      wrs++;
      last_wr = wr_data;
    end
    if (m_oe_n === 1'b0) begin
      togs += int'(m_o !== m_prev);
      m_prev = m_o;
    end
  end
  task automatic cmp(input string what, input logic [47:0] exp, input logic [47:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_bit(input string what, input logic exp, input logic got);
    cmp(what, {47'h0, exp}, {47'h0, got});
  endtask
  task automatic wrap_up();
    $display("errors=%0d check_count=%0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // One transfer of four data beats, with the start flag and the release judged.
  task automatic run(input logic [47:0] ca, input logic [7:0] mk);
    acks = 0;
    wrs = 0;
    togs = 0;
    cmds = 0;
    m_prev = 1'b0;
    fork
      host.frame(diff, lat, ca, 4, mk);
      begin
        repeat (6) @(negedge clk);
        cmp_bit("busy", 1'b1, busy);
        cmp_bit("flag oe", 1'b0, m_oe_n);
        cmp_bit("flag", lat, m_o);
      end
    join
    cmp("cmd", ca, cmd_addr);
    cmp("cmd count", 48'h1, 48'(cmds));
    cmp_bit("idle", 1'b0, busy);
    cmp_bit("dq oe", 1'b1, dq_oe_n);
    cmp_bit("strobe oe", 1'b1, m_oe_n);
  endtask
  task automatic sc_read(input logic d, input logic l);
    diff = d;
    lat = l;
    rd_data = 8'h10;
    run({1'b1, 47'h1234_5678}, 8'h00);
    cmp("rd acks", 48'h4, 48'(acks));
    cmp("rd last", 48'h13, {40'h0, last_rd});
    cmp("toggles", 48'(4 + 2 * int'(l)), 48'(togs));
  endtask
  task automatic sc_write();
    diff = 1'b1;
    lat = 1'b0;
    run(48'h0000_ABCD_0042, 8'h02);
    cmp("wr count", 48'h3, 48'(wrs));
    cmp("wr last", 48'hC3, {40'h0, last_wr});
  endtask
  task automatic sc_reset();
    fork
      host.frame(1'b0, 1'b1, {1'b1, 47'h5}, 4, 8'h00);
      begin
        repeat (20) @(negedge clk);
        rst_n = 1'b0;
        repeat (5) @(negedge clk);
        cmp_bit("rst busy", 1'b0, busy);
        cmp_bit("rst dq oe", 1'b1, dq_oe_n);
        cmp_bit("rst strobe oe", 1'b1, m_oe_n);
      end
    join
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask
  // Main sequence.
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (5) @(negedge clk);
    sc_read(1'b0, 1'b0);
    sc_read(1'b1, 1'b1);
    sc_write();
    sc_reset();
    sc_read(1'b1, 1'b0);
    wrap_up();
  end
  // Guard against a hang.
  initial begin
    #100000;
    errors++;
    wrap_up();
  end
endmodule
